// file: include/vendor_cfg_pkg.sv
`default_nettype none
package vendor_cfg_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] TX_MARGIN_OFS = 12'h860;
  localparam logic [11:0] CTRL3_OFS = 12'h864;
  localparam logic [11:0] CTRL4_OFS = 12'h868;
  localparam logic [11:0] CTRL5_OFS = 12'h86C;
  localparam logic [11:0] NTM_OFS = 12'h870;
  localparam logic [11:0] OPM_OFS = 12'h874;
  localparam logic [11:0] PME_OFS = 12'h878;

  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [31:0] TX_MARGIN_RST = 32'h0000_116B;
  localparam logic [31:0] TX_MARGIN_RW_MASK = 32'h0000_7FFF;
  localparam logic [31:0] CTRL3_RST = 32'h000F_0000;
  localparam logic [31:0] CTRL4_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL5_LOW_RST = 32'h3308_0008;
  localparam logic [31:0] CTRL5_LOW_MASK = 32'h3FFF_FFFF;
  localparam logic [31:0] FULL_RW_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] NTM_RST = 32'h0000_9014;
  localparam logic [31:0] NTM_RW_MASK = 32'h0000_00E0;
  localparam logic [15:0] OPM_RST_NINE = 16'h0022;
  localparam logic [15:0] OPM_RST_SIX = 16'h0062;
  localparam logic [15:0] OPM_RST_FIVE = 16'h0122;
  localparam logic [31:0] OPM_RW_MASK = 32'h0F00_0000;
  localparam logic [15:0] OPM_HW_MASK = 16'h061F;
  localparam logic [31:0] PME_RST = 32'h0000_000C;
  localparam logic [31:0] PME_RW_MASK = 32'h0000_000C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL5_ACK_BIT = 10;
  localparam int CTRL5_RATE_BIT = 30;
  localparam int CTRL5_LEGACY_BIT = 31;
  localparam int NTM_NT_BIT = 14;
  localparam int OPM_BIST_BIT = 0;
  localparam int OPM_IDDQ_BIT = 1;
  localparam int OPM_FAST_BIT = 2;
  localparam int OPM_DEBUG_BIT = 3;
  localparam int OPM_PHY_BIT = 4;
  localparam int OPM_PLL_BIT = 9;
  localparam int OPM_SCAN_BIT = 10;
  localparam int OPM_OPT_LSB = 24;
  localparam int OPM_OPT_W = 4;
  localparam int PME_CAP_BIT = 0;
  localparam int PME_TURNOFF_BIT = 1;
  localparam int PME_POWER_BIT = 2;
  localparam int PME_RESET_BIT = 3;
  localparam int PME_LINK_LSB = 16;
  localparam int TX_MARGIN_W = 15;

  // ****************************************
  // strap pin vector layout
  // ****************************************
  localparam int STRAP_BIST = 0;
  localparam int STRAP_IDDQ = 1;
  localparam int STRAP_FAST = 2;
  localparam int STRAP_DEBUG = 3;
  localparam int STRAP_PHY = 4;
  localparam int STRAP_PLL = 5;
  localparam int STRAP_SCAN = 6;
  localparam int STRAP_NT = 7;
  localparam int STRAP_PME = 8;
  localparam int STRAP_W = 9;
  localparam logic [1:0] SYNC_FILL = 2'h3;
  localparam int DOWN_PORTS = 5;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {VARIANT_NINE, VARIANT_SIX, VARIANT_FIVE} variant_type;
  typedef enum logic {ST_WAIT, ST_SAMPLED} sample_state_type;

endpackage
`default_nettype wire

// file: include/strap_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
// strap pins in, synchronised levels out
interface strap_sync_if;
  logic [vendor_cfg_pkg::STRAP_W-1:0] pins;
  logic [vendor_cfg_pkg::STRAP_W-1:0] level;
  logic agree;
  modport sync (input pins, output level, output agree);
  modport user (output pins, input level, input agree);
endinterface
`default_nettype wire

// file: verilog/strap_sync.sv
`timescale 1ns/100ps
`default_nettype none
module strap_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // strap carrier
  strap_sync_if.sync ss
);

  logic [vendor_cfg_pkg::STRAP_W-1:0] eq;
  logic [1:0] fill_q;

  // ****************************************
  // three-stage synchroniser per strap bit
  // ****************************************
  for (genvar i = 0; i < vendor_cfg_pkg::STRAP_W; i++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q <= 1'h0;
        s2_q <= 1'h0;
        s3_q <= 1'h0;
      end else begin
        s1_q <= ss.pins[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end
    assign eq[i] = (s2_q == s3_q);
    assign ss.level[i] = s3_q;
  end

  // pipeline fill counter, so reset zeros never count as agreement
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_q <= 2'h0;
    end else if (fill_q != vendor_cfg_pkg::SYNC_FILL) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  assign ss.agree = (fill_q == vendor_cfg_pkg::SYNC_FILL) && (&eq);

endmodule
`default_nettype wire

// file: verilog/switch_port_vendor_cfg_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - bit 31 of word five limits to first generation
// - bit 10 enables ack latency timer
// - bit 14 reflects sampled nontransparent strap
// - operating mode reports sampled strap flags
// - bit 0 shows event scheme enable, default 0
// - writing bit 1 requests turn-off message
// - bit 2 drives this port's power output
// - bit 3 low asserts attached device reset
// - bits 17:16 report attached link power state
// - 15-bit margin field, reset 116B, rest reserved
// - some registers exist only upstream or downstream
module switch_port_vendor_cfg_regs #(
  parameter bit IS_UPSTREAM = 1'b1,
  parameter int DOWN_INDEX = 1,
  parameter vendor_cfg_pkg::variant_type VARIANT = vendor_cfg_pkg::VARIANT_NINE
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // configuration access
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // strap pins and link status
  input wire logic [vendor_cfg_pkg::STRAP_W-1:0] hw_straps,
  input wire logic [1:0] link_power_state,
  input wire logic turnoff_done,
  // control outputs to the port logic
  output logic [vendor_cfg_pkg::TX_MARGIN_W-1:0] tx_margin,
  output logic [31:0] link_ctrl_word_three,
  output logic [31:0] link_ctrl_word_four,
  output logic legacy_rate_only_report,
  output logic ack_latency_timer_en,
  output logic rate_change_control,
  output logic [vendor_cfg_pkg::OPM_OPT_W-1:0] low_power_substate_option,
  output logic nontransparent_mode,
  output logic turnoff_req,
  // attached device pins
  output logic [vendor_cfg_pkg::DOWN_PORTS-1:0] port_power_gpio,
  output logic attached_reset_n
);

  // ****************************************
  // constants of this port function
  // ****************************************
  localparam logic [15:0] OPM_VARIANT_RST =
    (VARIANT == vendor_cfg_pkg::VARIANT_SIX) ? vendor_cfg_pkg::OPM_RST_SIX :
    (VARIANT == vendor_cfg_pkg::VARIANT_FIVE) ? vendor_cfg_pkg::OPM_RST_FIVE :
    vendor_cfg_pkg::OPM_RST_NINE;
  localparam logic [31:0] OPM_RST = {16'h0000, OPM_VARIANT_RST};
  localparam logic [31:0] CTRL5_RST =
    vendor_cfg_pkg::CTRL5_LOW_RST | ({31'h0, IS_UPSTREAM} << vendor_cfg_pkg::CTRL5_RATE_BIT);

  // ****************************************
  // declarations
  // ****************************************
  strap_sync_if ss ();
  vendor_cfg_pkg::sample_state_type state_q;
  logic [31:0] tx_q, tx_d, c3_q, c3_d, c4_q, c4_d, c5_q, c5_d;
  logic [31:0] ntm_q, ntm_d, ntm_w, opm_q, opm_d, opm_w, pme_q, pme_d, pme_w;
  logic [31:0] be_mask, rd_word, rd_pme;
  logic [15:0] opm_flags;
  logic wr_any, hit_tx, hit_c3, hit_c4, hit_c5, hit_ntm, hit_opm, hit_pme, sample_now;
  logic turnoff_set;
  logic cfg_ack_q;
  logic [31:0] cfg_rdata_q;
  logic [vendor_cfg_pkg::DOWN_PORTS-1:0] gpio_q, gpio_d;
  logic att_rst_q;

  // byte-lane merge of write data under a writable mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] rw);
    logic [31:0] m;
    m = rw & be_mask;
    return (old & ~m) | (cfg_wdata & m);
  endfunction

  // ****************************************
  // strap synchroniser
  // ****************************************
  assign ss.pins = hw_straps;
  strap_sync u_sync (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .ss (ss)
  );

  // ****************************************
  // address decode
  // ****************************************
  assign be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  assign wr_any = cfg_valid && cfg_write;
  assign hit_tx = IS_UPSTREAM && (cfg_addr == vendor_cfg_pkg::TX_MARGIN_OFS);
  assign hit_c3 = (cfg_addr == vendor_cfg_pkg::CTRL3_OFS);
  assign hit_c4 = IS_UPSTREAM && (cfg_addr == vendor_cfg_pkg::CTRL4_OFS);
  assign hit_c5 = (cfg_addr == vendor_cfg_pkg::CTRL5_OFS);
  assign hit_ntm = IS_UPSTREAM && (cfg_addr == vendor_cfg_pkg::NTM_OFS);
  assign hit_opm = (cfg_addr == vendor_cfg_pkg::OPM_OFS);
  assign hit_pme = !IS_UPSTREAM && (cfg_addr == vendor_cfg_pkg::PME_OFS);

  // ****************************************
  // next values, reserved bits masked
  // ****************************************
  // a process, so data and lane changes seen inside merge wake it too
  always_comb begin
    tx_d = (wr_any && hit_tx) ? merge(tx_q, vendor_cfg_pkg::TX_MARGIN_RW_MASK) : tx_q;
    c3_d = (wr_any && hit_c3) ? merge(c3_q, vendor_cfg_pkg::FULL_RW_MASK) : c3_q;
    c4_d = (wr_any && hit_c4) ? merge(c4_q, vendor_cfg_pkg::FULL_RW_MASK) : c4_q;
    c5_d = (wr_any && hit_c5) ? merge(c5_q, vendor_cfg_pkg::FULL_RW_MASK) : c5_q;
    ntm_w = (wr_any && hit_ntm) ? merge(ntm_q, vendor_cfg_pkg::NTM_RW_MASK) : ntm_q;
    opm_w = (wr_any && hit_opm) ? merge(opm_q, vendor_cfg_pkg::OPM_RW_MASK) : opm_q;
    pme_w = (wr_any && hit_pme) ? merge(pme_q, vendor_cfg_pkg::PME_RW_MASK) : pme_q;
  end
  assign sample_now = (state_q == vendor_cfg_pkg::ST_WAIT) && ss.agree;

  // hardware-sampled operating mode flags over the variant pattern
  always_comb begin
    opm_flags = OPM_VARIANT_RST;
    opm_flags[vendor_cfg_pkg::OPM_BIST_BIT] = ss.level[vendor_cfg_pkg::STRAP_BIST];
    opm_flags[vendor_cfg_pkg::OPM_IDDQ_BIT] = ss.level[vendor_cfg_pkg::STRAP_IDDQ];
    opm_flags[vendor_cfg_pkg::OPM_FAST_BIT] = ss.level[vendor_cfg_pkg::STRAP_FAST];
    opm_flags[vendor_cfg_pkg::OPM_DEBUG_BIT] = ss.level[vendor_cfg_pkg::STRAP_DEBUG];
    opm_flags[vendor_cfg_pkg::OPM_PHY_BIT] = ss.level[vendor_cfg_pkg::STRAP_PHY];
    opm_flags[vendor_cfg_pkg::OPM_PLL_BIT] = ss.level[vendor_cfg_pkg::STRAP_PLL];
    opm_flags[vendor_cfg_pkg::OPM_SCAN_BIT] = ss.level[vendor_cfg_pkg::STRAP_SCAN];
  end

  // strap capture happens once, after synchroniser agreement
  always_comb begin
    opm_d = opm_w;
    ntm_d = ntm_w;
    pme_d = pme_w;
    if (sample_now) begin
      opm_d[15:0] = (opm_w[15:0] & ~vendor_cfg_pkg::OPM_HW_MASK) |
                    (opm_flags & vendor_cfg_pkg::OPM_HW_MASK);
      ntm_d[vendor_cfg_pkg::NTM_NT_BIT] = ss.level[vendor_cfg_pkg::STRAP_NT];
      pme_d[vendor_cfg_pkg::PME_CAP_BIT] = ss.level[vendor_cfg_pkg::STRAP_PME];
    end
    // software set beats the completion clear
    pme_d[vendor_cfg_pkg::PME_TURNOFF_BIT] = turnoff_set ||
      (pme_q[vendor_cfg_pkg::PME_TURNOFF_BIT] && !turnoff_done);
  end
  assign turnoff_set = !IS_UPSTREAM && wr_any && hit_pme && cfg_be[0] &&
                       cfg_wdata[vendor_cfg_pkg::PME_TURNOFF_BIT];

  // ****************************************
  // read selection
  // ****************************************
  assign rd_pme = {14'h0000, link_power_state, pme_q[15:0]};
  assign rd_word = hit_tx ? tx_q :
                   hit_c3 ? c3_q :
                   hit_c4 ? c4_q :
                   hit_c5 ? c5_q :
                   hit_ntm ? ntm_q :
                   hit_opm ? opm_q :
                   hit_pme ? rd_pme : 32'h0000_0000;

  // per-port power output, only this function's bit
  for (genvar i = 0; i < vendor_cfg_pkg::DOWN_PORTS; i++) begin : g_gpio
    assign gpio_d[i] = !IS_UPSTREAM && (DOWN_INDEX == i + 1) &&
                       pme_q[vendor_cfg_pkg::PME_CAP_BIT] &&
                       pme_q[vendor_cfg_pkg::PME_POWER_BIT];
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= vendor_cfg_pkg::TX_MARGIN_RST;
      c3_q <= vendor_cfg_pkg::CTRL3_RST;
      c4_q <= vendor_cfg_pkg::CTRL4_RST;
      c5_q <= CTRL5_RST;
      ntm_q <= vendor_cfg_pkg::NTM_RST;
      opm_q <= OPM_RST;
      pme_q <= vendor_cfg_pkg::PME_RST;
    end else begin
      tx_q <= tx_d;
      c3_q <= c3_d;
      c4_q <= c4_d;
      c5_q <= c5_d;
      ntm_q <= ntm_d;
      opm_q <= opm_d;
      pme_q <= pme_d;
    end
  end

  // strap sampling sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= vendor_cfg_pkg::ST_WAIT;
    end else begin
      case (state_q)
        vendor_cfg_pkg::ST_WAIT: begin
          if (ss.agree) begin
            state_q <= vendor_cfg_pkg::ST_SAMPLED;
          end
        end
        default: begin
          state_q <= vendor_cfg_pkg::ST_SAMPLED;
        end
      endcase
    end
  end

  // access answer and attached device pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ack_q <= 1'h0;
      cfg_rdata_q <= 32'h0000_0000;
      gpio_q <= '0;
      att_rst_q <= 1'h1;
    end else begin
      cfg_ack_q <= cfg_valid;
      cfg_rdata_q <= (cfg_valid && !cfg_write) ? rd_word : 32'h0000_0000;
      gpio_q <= gpio_d;
      att_rst_q <= !(!IS_UPSTREAM && pme_q[vendor_cfg_pkg::PME_CAP_BIT] &&
                     !pme_q[vendor_cfg_pkg::PME_RESET_BIT]);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign cfg_ack = cfg_ack_q;
  assign cfg_rdata = cfg_rdata_q;
  assign tx_margin = tx_q[vendor_cfg_pkg::TX_MARGIN_W-1:0];
  assign link_ctrl_word_three = c3_q;
  assign link_ctrl_word_four = c4_q;
  assign legacy_rate_only_report = c5_q[vendor_cfg_pkg::CTRL5_LEGACY_BIT];
  assign ack_latency_timer_en = c5_q[vendor_cfg_pkg::CTRL5_ACK_BIT];
  assign rate_change_control = c5_q[vendor_cfg_pkg::CTRL5_RATE_BIT];
  assign low_power_substate_option =
    opm_q[vendor_cfg_pkg::OPM_OPT_LSB +: vendor_cfg_pkg::OPM_OPT_W];
  assign nontransparent_mode = ntm_q[vendor_cfg_pkg::NTM_NT_BIT];
  assign turnoff_req = pme_q[vendor_cfg_pkg::PME_TURNOFF_BIT];
  assign port_power_gpio = gpio_q;
  assign attached_reset_n = att_rst_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_legacy;
    cfg_valid && cfg_write && cfg_be[3] && cfg_addr == vendor_cfg_pkg::CTRL5_OFS
      |=> legacy_rate_only_report == $past(cfg_wdata[vendor_cfg_pkg::CTRL5_LEGACY_BIT]);
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy rate bit not updated");

  property p_ack_timer;
    cfg_valid && cfg_write && cfg_be[1] && cfg_addr == vendor_cfg_pkg::CTRL5_OFS
      |=> ack_latency_timer_en == $past(cfg_wdata[vendor_cfg_pkg::CTRL5_ACK_BIT]);
  endproperty
  a_ack_timer: assert property (p_ack_timer) else $error("ack timer enable wrong");

  property p_nt_strap;
    IS_UPSTREAM && sample_now
      |=> nontransparent_mode == $past(ss.level[vendor_cfg_pkg::STRAP_NT]);
  endproperty
  a_nt_strap: assert property (p_nt_strap) else $error("strap not reflected");

  property p_opm_reset;
    state_q == vendor_cfg_pkg::ST_WAIT |-> opm_q[15:0] == OPM_VARIANT_RST;
  endproperty
  a_opm_reset: assert property (p_opm_reset) else $error("mode reset value wrong");

  property p_opm_read;
    cfg_valid && !cfg_write && hit_opm && state_q == vendor_cfg_pkg::ST_SAMPLED
      |=> cfg_ack && cfg_rdata[15:11] == 5'h00 && cfg_rdata[6] == OPM_VARIANT_RST[6]
          && cfg_rdata[8] == OPM_VARIANT_RST[8];
  endproperty
  a_opm_read: assert property (p_opm_read) else $error("mode read wrong");

  property p_cap_ro;
    cfg_valid && cfg_write && hit_pme && !sample_now |=> $stable(pme_q[0]);
  endproperty
  a_cap_ro: assert property (p_cap_ro) else $error("capability bit written");

  property p_turnoff;
    turnoff_set |=> turnoff_req;
  endproperty
  a_turnoff: assert property (p_turnoff) else $error("turn-off request lost");

  property p_gpio;
    port_power_gpio != '0 |-> $past(pme_q[0]) && !IS_UPSTREAM;
  endproperty
  a_gpio: assert property (p_gpio) else $error("power output without scheme");

  property p_reset_out;
    !pme_q[0] ##1 1'h1 |-> attached_reset_n;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset driven while disabled");

  property p_link;
    cfg_valid && !cfg_write && hit_pme |=> cfg_rdata[17:16] == $past(link_power_state);
  endproperty
  a_link: assert property (p_link) else $error("link state read wrong");

  property p_margin;
    cfg_valid && !cfg_write && hit_tx |=> cfg_rdata[31:15] == 17'h00000;
  endproperty
  a_margin: assert property (p_margin) else $error("margin reserved bits set");

  property p_absent;
    cfg_valid && !cfg_write && !IS_UPSTREAM && cfg_addr == vendor_cfg_pkg::TX_MARGIN_OFS
      |=> cfg_rdata == 32'h0000_0000;
  endproperty
  a_absent: assert property (p_absent) else $error("absent register answered");

  property p_ntm_rsvd;
    cfg_valid && !cfg_write && hit_ntm |=> cfg_rdata[31:16] == 16'h0000;
  endproperty
  a_ntm_rsvd: assert property (p_ntm_rsvd) else $error("reserved bits nonzero");

  c_sampled: cover property (sample_now);
  c_turnoff: cover property (turnoff_req ##1 turnoff_done ##1 !turnoff_req);
  c_att_reset: cover property (!attached_reset_n);
  c_legacy: cover property ($rose(legacy_rate_only_report));

endmodule
`default_nettype wire

// file: bench/attached_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// device hanging off one downstream port
// ****************************************
module attached_dev_model (
  // clock
  input wire logic ref_clk,
  // pins driven by the port
  input wire logic power_on,
  input wire logic reset_n,
  input wire logic turnoff_req,
  // bench control
  input wire logic [1:0] state_cmd,
  input wire logic [7:0] reply_delay,
  // answers back to the port
  output logic [1:0] link_state,
  output var logic turnoff_done
);
  int cnt = 0;

  // held in reset or unpowered, the link is down
  assign link_state = (!reset_n || !power_on) ? 2'h3 : state_cmd;

  // answer a turn-off request with a single pulse after the set delay
  always @(posedge ref_clk) begin
    turnoff_done <= 1'b0;
    if (turnoff_req && !turnoff_done) begin
      cnt <= cnt + 1;
      if (cnt >= int'(reply_delay)) begin
        turnoff_done <= 1'b1;
        cnt <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int DI = 2;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_valid = 1'b0;
  logic cfg_write = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [8:0] hw_straps = 9'h000;
  logic [1:0] state_cmd = 2'h0;
  logic [7:0] reply_delay = 8'h00;
  logic [1:0] lps;
  logic done;
  // index 0 is the downstream function, 1 the upstream one, 2 a five-port downstream one
  logic ack [3];
  logic [31:0] rd [3];
  logic [14:0] txm [3];
  logic [31:0] w3 [3];
  logic [31:0] w4 [3];
  logic leg [3];
  logic ackt [3];
  logic rcc [3];
  logic [3:0] lpo [3];
  logic ntm [3];
  logic treq [3];
  logic [4:0] gpio [3];
  logic arst [3];
  logic [31:0] m [2][7];
  int n_errors = 0;
  int samples_checked = 0;

  // ****************************************
  // clock, duts and attached device
  // ****************************************
  always #25 ref_clk = ~ref_clk;

  for (genvar r = 0; r < 3; r++) begin : g_role
    switch_port_vendor_cfg_regs #(
      .IS_UPSTREAM(r == 1),
      .DOWN_INDEX(DI),
      .VARIANT(r == 1 ? vendor_cfg_pkg::VARIANT_NINE :
        r == 2 ? vendor_cfg_pkg::VARIANT_FIVE : vendor_cfg_pkg::VARIANT_SIX)
    ) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(ack[r]),
      .cfg_rdata(rd[r]), .hw_straps(hw_straps), .link_power_state(lps),
      .turnoff_done(done), .tx_margin(txm[r]), .link_ctrl_word_three(w3[r]),
      .link_ctrl_word_four(w4[r]), .legacy_rate_only_report(leg[r]),
      .ack_latency_timer_en(ackt[r]), .rate_change_control(rcc[r]),
      .low_power_substate_option(lpo[r]), .nontransparent_mode(ntm[r]),
      .turnoff_req(treq[r]), .port_power_gpio(gpio[r]), .attached_reset_n(arst[r])
    );
  end

  attached_dev_model u_dev (
    .ref_clk(ref_clk), .power_on(gpio[0][DI-1]), .reset_n(arst[0]),
    .turnoff_req(treq[0]), .state_cmd(state_cmd), .reply_delay(reply_delay),
    .link_state(lps), .turnoff_done(done)
  );

  // ****************************************
  // reference model
  // ****************************************
  function automatic bit pres(int r, logic [11:0] a);
    if (a < 12'h860 || a > 12'h878 || a[1:0] != 2'h0) return 1'b0;
    if (r == 1) return a != 12'h878;
    return a != 12'h860 && a != 12'h868 && a != 12'h870;
  endfunction

  function automatic logic [31:0] exp_rd(int r, logic [11:0] a);
    logic [31:0] v;
    if (!pres(r, a)) return 32'h0;
    v = m[r % 2][(a - 12'h860) >> 2];
    if (a == 12'h870) v[14] = hw_straps[7];
    if (a == 12'h874) v[15:0] = ((r == 1 ? 16'h0022 : r == 2 ? 16'h0122 : 16'h0062) & ~16'h061F)
      | {5'h0, hw_straps[6:5], 4'h0, hw_straps[4:0]};
    if (a == 12'h878) begin
      v[0] = hw_straps[8];
      v[17:16] = lps;
    end
    return v;
  endfunction

  // ****************************************
  // bench tasks
  // ****************************************
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one access; bit 1 of the event register is checked on its own
  task automatic acc(bit wr, logic [11:0] a, logic [3:0] be, logic [31:0] wd);
    logic [31:0] wm [7];
    logic [31:0] bem;
    logic [31:0] km;
    int i;
    wm = '{32'h7FFF, '1, '1, '1, 32'hE0, 32'h0F00_0000, 32'hC};
    @(posedge ref_clk);
    cfg_valid <= 1'b1;
    cfg_write <= wr;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= wd;
    @(posedge ref_clk);
    cfg_valid <= 1'b0;
    #1;
    bem = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    i = (int'(a) - 'h860) / 4;
    // only the turn-off bit of the event register is left to its own checks
    km = (a == 12'h878) ? ~32'h2 : 32'hFFFF_FFFF;
    for (int r = 0; r < 2; r++) begin
      chk("ack", 32'(ack[r]), 32'h1);
      if (wr && pres(r, a)) m[r][i] = (m[r][i] & ~(wm[i] & bem)) | (wd & wm[i] & bem);
      chk("rdata", rd[r] & km, wr ? 32'h0 : exp_rd(r, a) & km);
    end
    chk("ack_five", 32'(ack[2]), 32'h1);
    chk("rdata_five", rd[2] & km, wr ? 32'h0 : exp_rd(2, a) & km);
  endtask

  // control outputs after the pins have followed
  task automatic outs;
    @(posedge ref_clk);
    #1;
    for (int r = 0; r < 2; r++) begin
      chk("word3", w3[r], m[r][1]);
      chk("legacy", 32'(leg[r]), 32'(m[r][3][31]));
      chk("acktimer", 32'(ackt[r]), 32'(m[r][3][10]));
      chk("ratectl", 32'(rcc[r]), 32'(m[r][3][30]));
      chk("substate", 32'(lpo[r]), 32'(m[r][5][27:24]));
    end
    chk("margin", 32'(txm[1]), m[1][0]);
    chk("word4", w4[1], m[1][2]);
    chk("ntmode", 32'(ntm[1]), 32'(hw_straps[7]));
    chk("gpio", 32'(gpio[0]), hw_straps[8] ? 32'(m[0][6][2]) << (DI - 1) : 32'h0);
    chk("gpio_up", 32'(gpio[1]), 32'h0);
    chk("devrst", 32'(arst[0]), 32'(!(hw_straps[8] && !m[0][6][3])));
  endtask

  task automatic rst_cycle(logic [8:0] s);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    hw_straps <= s;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    for (int r = 0; r < 2; r++)
      m[r] = '{32'h116B, 32'h000F_0000, 32'h0, 32'h3308_0008 | (32'(r) << 30), 32'h9014,
        32'h0, 32'hC};
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [11:0] a;
    int k;
    void'($urandom(32'h7d956c25));
    for (int p = 0; p < 2; p++) begin
      reply_delay <= p == 1 ? 8'h00 : 8'h14;
      rst_cycle({p[0], 8'($urandom)});
      for (int x = 'h858; x <= 'h880; x += 4) acc(0, 12'(x), 4'hF, 32'h0);
      outs;
      repeat (30) begin
        a = 12'h858 + 12'(($urandom % 11) * 4);
        acc(1, a, 4'($urandom), $urandom & ~32'h2);
        acc(0, a, 4'hF, 32'h0);
        outs;
      end
      acc(1, 12'h878, 4'h1, 32'hC);
      for (int s = 0; s < 4; s++) begin
        @(posedge ref_clk);
        state_cmd <= 2'(s);
        acc(0, 12'h878, 4'hF, 32'h0);
      end
      acc(1, 12'h878, 4'h1, 32'hE);
      outs;
      chk("turnoff_up", 32'(treq[1]), 32'h0);
      if (p == 0) begin
        chk("turnoff", 32'(treq[0]), 32'h1);
        acc(0, 12'h878, 4'hF, 32'h0);
        chk("turnoff_rd", 32'(rd[0][1]), 32'h1);
      end
      k = 0;
      while (treq[0] !== 1'b0 && k < 100) begin
        @(posedge ref_clk);
        k++;
      end
      if (k == 100) n_errors++;
      #1;
      chk("turnoff_clr", 32'(treq[0]), 32'h0);
    end
    results;
  end

  // a hang counts as a failure
  initial begin
    #500000;
    n_errors++;
    results;
  end
endmodule
`default_nettype wire
